// file: dv/pll_serial_word_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
module pll_serial_word_loader_test;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic sdata, sclk, sen;
    logic sel = 1'b1;
    logic pre = 1'b0;
    logic rosc = 1'b0;
    logic lock = 1'b1;
    logic mod_hi, p89, src, snk, mref, mrf, mon;
    logic [3:0] gain;
    int n_mismatch = 0;
    int num_checks = 0;
    int pc = 0;
    int rc = 0;
    always #12.5 clock_i = ~clock_i;
    // divided rf and reference stand-ins, slow enough for the pin synchronisers
    always @(negedge clock_i) begin
        pc = (pc + 1) % 5;
        rc = (rc + 1) % 4;
        if (pc == 0) pre <= ~pre;
        if (rc == 0) rosc <= ~rosc;
        if (src === 1'b1 && snk === 1'b1) begin
            n_mismatch++;
            $display("ERROR pump source and sink expected 0 seen 1");
        end
    end
    serial_host u_serial_host (.clock_i(clock_i), .data_o(sdata), .sclk_o(sclk), .en_o(sen));
    pll_serial_word_loader u_pll_serial_word_loader (
        .clock_i(clock_i), .reset_i(reset_i), .serial_data_i(sdata), .serial_clk_i(sclk),
        .serial_en_i(sen), .buffer_select_pin_i(sel), .prescaler_out_i(pre), .ref_osc_i(rosc),
        .lock_detect_i(lock), .modulus_high_o(mod_hi), .prescaler_8_9_o(p89),
        .gain_mult_x2_o(gain), .pump_source_o(src), .pump_sink_o(snk),
        .divided_ref_monitor_o(mref), .divided_rf_monitor_o(mrf), .monitors_on_o(mon));
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [23:0] dw(input logic [3:0] a, input logic [14:0] m,
                                       input logic [1:0] g, input logic [1:0] dest);
        return {1'b0, g[1], g[0], m, a, dest}; // g is {high, low}
    endfunction
    task automatic settle();
        repeat (400) @(negedge clock_i);
    endtask
    task automatic reset_values();
        check("gain after reset", 4'h2, gain);
        check("monitors after reset", 4'h0, {3'h0, mon});
        check("mode after reset", 4'h0, {3'h0, p89});
    endtask
    task automatic power_and_modulus();
        logic [17:0] rw;
        int seen;
        for (int p = 0; p < 4; p++) begin
            rw = {p[0], p[1:0], 13'h0002, 2'h3};
            u_serial_host.send({6'h00, rw}, 18);
            settle();
            check("monitors on", {3'h0, p != 0}, {3'h0, mon});
            check("modulus mode", {3'h0, p[0]}, {3'h0, p89});
            seen = 0;
            repeat (300) @(negedge clock_i) if (src === 1'b1) seen++;
            check("pump source", {3'h0, p < 2}, {3'h0, seen != 0});
        end
        u_serial_host.send({6'h00, 1'b0, 2'h1, 13'h0002, 2'h3}, 18);
    endtask
    task automatic gain_codes();
        logic [3:0] exp [4] = '{4'h2, 4'h3, 4'h5, 4'h8};
        logic [1:0] code [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
        for (int i = 0; i < 4; i++) begin
            u_serial_host.send(dw(4'h2, 15'h0008, code[i], 2'h0), 24);
            settle();
            check("gain primary", exp[i], gain);
        end
    endtask
    task automatic alternate_and_select();
        u_serial_host.send(dw(4'h1, 15'h0009, 2'h0, 2'h2), 24);
        settle();
        check("gain kept", 4'h8, gain);
        sel <= 1'b0;
        settle();
        check("gain alternate", 4'h2, gain);
        sel <= 1'b1;
        settle();
        check("gain back", 4'h8, gain);
        u_serial_host.send({18'h0, 4'h3, 2'h1}, 6);
        settle();
        check("gain after a only", 4'h8, gain);
    endtask
    task automatic check_span(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    function automatic logic pick(input logic [1:0] which);
        case (which)
            2'h0:    return mrf;
            2'h1:    return mref;
            default: return mod_hi;
        endcase
    endfunction
    // pulse to pulse gap for the monitors, high run length for the modulus
    task automatic gap(input logic [1:0] which, output logic [7:0] n);
        n = 8'h00;
        while (pick(which) === 1'b1) @(negedge clock_i);
        while (pick(which) !== 1'b1) @(negedge clock_i);
        if (which == 2'h2) begin
            while (pick(which) === 1'b1) begin
                @(negedge clock_i);
                n = n + 8'h01;
            end
        end else begin
            @(negedge clock_i);
            n = 8'h01;
            while (pick(which) !== 1'b1) begin
                @(negedge clock_i);
                n = n + 8'h01;
            end
        end
    endtask
    // stand-ins: prescaler period 10 clocks, reference period 8; active M=8, A=3, R=2
    task automatic monitors_and_sense();
        logic [7:0] n;
        int src_n;
        int snk_n;
        gap(2'h0, n);
        check_span("rf monitor gap", 8'h50, n);
        gap(2'h1, n);
        check_span("ref monitor gap", 8'h10, n);
        gap(2'h2, n);
        check_span("modulus high span", 8'h1E, n);
        u_serial_host.send({1'b1, 2'h3, 15'h0008, 4'h3, 2'h0}, 24);
        settle();
        gap(2'h0, n);
        check_span("rf monitor swapped", 8'h10, n);
        gap(2'h1, n);
        check_span("ref monitor swapped", 8'h50, n);
        src_n = 0;
        snk_n = 0;
        repeat (300) begin
            @(negedge clock_i);
            if (src === 1'b1) src_n++;
            if (snk === 1'b1) snk_n++;
        end
        check("pump sink swapped", 4'h1, {3'h0, snk_n != 0});
        check("pump source swapped", 4'h0, {3'h0, src_n != 0});
        check("gain with sense", 4'h8, gain);
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(negedge clock_i);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (16) @(negedge clock_i);
        reset_i <= 1'b0;
        repeat (20) @(negedge clock_i);
        reset_values();
        power_and_modulus();
        gain_codes();
        alternate_and_select();
        monitors_and_sense();
        results();
    end
endmodule
`default_nettype wire

// file: dv/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic clock_i, // bench clock, pacing only
    output logic      data_o,  // serial data pin
    output logic      sclk_o,  // serial clock pin
    output logic      en_o     // serial enable pin
);
    initial begin
        data_o = 1'b0;
        sclk_o = 1'b0;
        en_o   = 1'b0;
    end
    // msb first so select bits land lowest; n is 24, 18 or 6 by word kind
    task automatic send(input logic [23:0] w, input int n);
        @(negedge clock_i);
        en_o = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            data_o = w[i];
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b0;
        end
        en_o   = 1'b0;
        // released line shows the inverse so a stale bit never looks valid
        data_o = ~data_o;
        repeat (8) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

// file: src/pll_pkg.sv
// Behaviour
// - serial data shifts in on each rising serial clock while enable is high.
// - shifting while enable is high leaves dividers and the running count alone.
// - falling enable copies the shift register into exactly one destination.
// - 24-bit shift register; its two low bits pick the destination.
// - primary buffer stores upper 22 bits: 19 divider bits, gain and sense.
// - alternate buffer keeps the same layout as the primary buffer.
// - two gain bits set pump multiplier 1, 1.5, 2.5 or 4.
// - sense bit swaps detector inputs and swaps the two monitor outputs.
// - buffer select high picks primary buffer, low picks alternate.
// - writing the inactive buffer leaves the running dividers undisturbed.
// - divider word moves into A and M only while remaining M count exceeds 3.
// - divider update completes within (3+M)N+A RF periods plus 50 ns.
// - reference word uses 16 bits: 13 divider, 2 power, 1 modulus.
// - power bits choose monitor outputs and pump on, off or lock-gated.
// - modulus bit 1 selects 8/9 prescaler, 0 selects 16/17.
// - reference word moves in while remaining R count exceeds 1 or the running R is at most 1.
// - A-only write changes just the active A bits at end of M count.
// - two detector flops set by M and R outputs, cleared once both set.
// - cycle starts at modulus N+1, drops to N at A, resets at M.
// - reference divider accepts any ratio from 1 to 8191.
package pll_pkg;
    localparam int SR_W       = 24;
    localparam int DEST_LO    = 0;
    localparam int DEST_HI    = 1;
    // divider word fields, as positions in the shift register
    localparam int A_LSB      = 2;
    localparam int A_W        = 4;
    localparam int M_LSB      = 6;
    localparam int M_W        = 15;
    localparam int GAIN_LO    = 21;
    localparam int GAIN_HI    = 22;
    localparam int SENSE_BIT  = 23;
    localparam int DIVW_LSB   = 2;
    localparam int DIVW_W     = 22;
    // reference word fields
    localparam int R_LSB      = 2;
    localparam int R_W        = 13;
    localparam int PWR_LO     = 15;
    localparam int PWR_HI     = 16;
    localparam int MOD_BIT    = 17;
    localparam int REFW_W     = 16;
    // positions inside a stored 22-bit divider word
    localparam int W_A_LSB    = 0;
    localparam int W_M_LSB    = 4;
    localparam int W_G_LSB    = 19;
    localparam int W_SENSE    = 21;
    // gating thresholds
    localparam logic [M_W-1:0] M_GATE = 15'h0003;
    localparam logic [R_W-1:0] R_GATE = 13'h0001;
    // reset values (no documented reset; chosen to run a short cycle)
    localparam logic [DIVW_W-1:0] DIVW_RST = 22'h00_0040;
    localparam logic [REFW_W-1:0] REFW_RST = 16'h0001;
    // destination codes {dest_sel_high, dest_sel_low}
    typedef enum logic [1:0] {
        DEST_PRIMARY   = 2'h0,
        DEST_A_ONLY    = 2'h1,
        DEST_ALTERNATE = 2'h2,
        DEST_REFERENCE = 2'h3
    } dest_t;
    // power codes {pwr_ctl_high, pwr_ctl_low}
    localparam logic [1:0] PWR_MON_OFF  = 2'h0;
    localparam logic [1:0] PWR_ALL_ON   = 2'h1;
    localparam logic [1:0] PWR_PUMP_OFF = 2'h2;
    localparam logic [1:0] PWR_LOCK_GATE = 2'h3;
    // timing
    localparam int CLK_NS     = 25;
    localparam int SLACK_NS   = 50;
    localparam int SLACK_CYC  = (SLACK_NS / CLK_NS) < 1 ? 1 : (SLACK_NS / CLK_NS);
    localparam int SYNC_W     = 6;
endpackage

// file: src/pll_serial_word_loader.sv
`timescale 1ns/1ps
`default_nettype none
module pll_serial_word_loader (
    input  wire logic       clock_i,               // 40 MHz system clock
    input  wire logic       reset_i,               // async reset, high
    input  wire logic       serial_data_i,         // serial data pin
    input  wire logic       serial_clk_i,          // serial clock pin
    input  wire logic       serial_en_i,           // serial enable pin
    input  wire logic       buffer_select_pin_i,   // high: primary, low: alternate
    input  wire logic       prescaler_out_i,       // prescaler output pin
    input  wire logic       ref_osc_i,             // reference oscillator pin
    input  wire logic       lock_detect_i,         // lock detector, high in lock
    output logic            modulus_high_o,        // prescaler at N+1
    output logic            prescaler_8_9_o,       // 8/9 mode, else 16/17
    output logic [3:0]      gain_mult_x2_o,        // pump multiplier times two
    output logic            pump_source_o,         // pump source drive
    output logic            pump_sink_o,           // pump sink drive
    output logic            divided_ref_monitor_o, // monitor output 1
    output logic            divided_rf_monitor_o,  // monitor output 2
    output logic            monitors_on_o          // monitor buffers powered
);
    // ---- pin synchronisers
    logic [pll_pkg::SYNC_W-1:0] pins;
    logic [pll_pkg::SYNC_W-1:0] s1_r;
    logic [pll_pkg::SYNC_W-1:0] s2_r;
    logic [pll_pkg::SYNC_W-1:0] s3_r;
    assign pins = {lock_detect_i, ref_osc_i, prescaler_out_i,
                   buffer_select_pin_i, serial_en_i, serial_clk_i};

    genvar gi;
    generate
        for (gi = 0; gi < pll_pkg::SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pins[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                end
            end
        end
    endgenerate

    logic data_s1_r;
    logic data_s2_r;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            data_s1_r <= 1'b0;
            data_s2_r <= 1'b0;
        end else begin
            data_s1_r <= serial_data_i;
            data_s2_r <= data_s1_r;
        end
    end

    logic sclk_rise;
    logic en_level;
    logic en_fall;
    logic sel_level;
    logic sel_toggle;
    logic rf_tick;
    logic lock_level;
    assign sclk_rise  = s2_r[0] & ~s3_r[0];
    assign en_level   = s2_r[1];
    assign en_fall    = ~s2_r[1] & s3_r[1];
    assign sel_level  = s2_r[2];
    assign sel_toggle = s2_r[2] ^ s3_r[2];
    assign rf_tick    = s2_r[3] & ~s3_r[3];
    assign lock_level = s2_r[5];

    // ---- shift register, msb first so the select bits land lowest
    logic [pll_pkg::SR_W-1:0] sr_r;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sr_r <= 24'h00_0000;
        end else if (sclk_rise && en_level) begin
            sr_r <= {sr_r[pll_pkg::SR_W-2:0], data_s2_r};
        end
    end

    pll_pkg::dest_t dest;
    assign dest = pll_pkg::dest_t'(sr_r[pll_pkg::DEST_HI:pll_pkg::DEST_LO]);

    // ---- buffers; the three stored words change only when enable falls
    logic [pll_pkg::DIVW_W-1:0] primary_divider_word_r;
    logic [pll_pkg::DIVW_W-1:0] alternate_divider_word_r;
    logic [pll_pkg::REFW_W-1:0] reference_config_word_r;
    logic [pll_pkg::DIVW_W-1:0] active_word;
    logic [pll_pkg::A_W-1:0]    new_a;
    assign active_word = sel_level ? primary_divider_word_r : alternate_divider_word_r;
    assign new_a       = sr_r[pll_pkg::A_LSB +: pll_pkg::A_W];

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            primary_divider_word_r   <= pll_pkg::DIVW_RST;
            alternate_divider_word_r <= pll_pkg::DIVW_RST;
            reference_config_word_r  <= pll_pkg::REFW_RST;
        end else if (en_fall) begin
            case (dest)
                pll_pkg::DEST_PRIMARY:
                    primary_divider_word_r <= sr_r[pll_pkg::DIVW_LSB +: pll_pkg::DIVW_W];
                pll_pkg::DEST_ALTERNATE:
                    alternate_divider_word_r <= sr_r[pll_pkg::DIVW_LSB +: pll_pkg::DIVW_W];
                pll_pkg::DEST_A_ONLY: begin
                    if (sel_level) begin
                        primary_divider_word_r[pll_pkg::W_A_LSB +: pll_pkg::A_W] <= new_a;
                    end else begin
                        alternate_divider_word_r[pll_pkg::W_A_LSB +: pll_pkg::A_W] <= new_a;
                    end
                end
                pll_pkg::DEST_REFERENCE:
                    reference_config_word_r <= sr_r[pll_pkg::R_LSB +: pll_pkg::REFW_W];
                default: ;
            endcase
        end
    end

    // a write to the inactive buffer raises no request
    logic wr_active;
    assign wr_active = en_fall && ((dest == pll_pkg::DEST_A_ONLY)
                    || (dest == pll_pkg::DEST_PRIMARY && sel_level)
                    || (dest == pll_pkg::DEST_ALTERNATE && !sel_level));

    // ---- divider shadow and working set; the shadow loads at the M gate, working values only at the cycle boundary
    logic [pll_pkg::DIVW_W-1:0] shadow_r;
    logic [pll_pkg::A_W-1:0]    a_work_r;
    logic [pll_pkg::M_W-1:0]    m_work_r;
    logic [1:0]                 gain_r;
    logic                       sense_r;
    logic [pll_pkg::A_W-1:0]    a_cnt_r;
    logic [pll_pkg::M_W-1:0]    m_cnt_r;
    logic                       mod_hi_r;
    logic                       m_out_r;
    logic                       div_pend_r;
    logic [pll_pkg::M_W-1:0]    m_remain;
    logic                       m_end;
    logic                       div_gate;
    logic [pll_pkg::A_W-1:0]    a_next;

    assign m_remain = m_work_r - m_cnt_r;
    assign m_end    = rf_tick && (m_cnt_r + 15'h0001 >= m_work_r);
    assign div_gate = m_remain > pll_pkg::M_GATE;
    assign a_next   = shadow_r[pll_pkg::W_A_LSB +: pll_pkg::A_W];

    // request held until remaining M count allows the copy
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div_pend_r <= 1'b0;
            shadow_r   <= pll_pkg::DIVW_RST;
        end else begin
            if (div_pend_r && div_gate) begin
                shadow_r   <= active_word;
                div_pend_r <= 1'b0;
            end
            if (wr_active || sel_toggle) begin   // set wins over the copy clear
                div_pend_r <= 1'b1;
            end
        end
    end

    // A and M counters; working values swap only when the cycle wraps
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            a_work_r <= pll_pkg::DIVW_RST[pll_pkg::W_A_LSB +: pll_pkg::A_W];
            m_work_r <= pll_pkg::DIVW_RST[pll_pkg::W_M_LSB +: pll_pkg::M_W];
            gain_r   <= pll_pkg::DIVW_RST[pll_pkg::W_G_LSB +: 2];
            sense_r  <= pll_pkg::DIVW_RST[pll_pkg::W_SENSE];
            a_cnt_r  <= 4'h0;
            m_cnt_r  <= 15'h0000;
            mod_hi_r <= 1'b0;
            m_out_r  <= 1'b0;
        end else begin
            m_out_r <= 1'b0;
            if (m_end) begin
                a_work_r <= a_next;
                m_work_r <= shadow_r[pll_pkg::W_M_LSB +: pll_pkg::M_W];
                gain_r   <= shadow_r[pll_pkg::W_G_LSB +: 2];
                sense_r  <= shadow_r[pll_pkg::W_SENSE];
                a_cnt_r  <= 4'h0;
                m_cnt_r  <= 15'h0000;
                mod_hi_r <= (a_next != 4'h0);
                m_out_r  <= 1'b1;
            end else if (rf_tick) begin
                m_cnt_r <= m_cnt_r + 15'h0001;
                if (mod_hi_r) begin
                    a_cnt_r <= a_cnt_r + 4'h1;
                    if (a_cnt_r + 4'h1 >= a_work_r) begin
                        mod_hi_r <= 1'b0;
                    end
                end
            end
        end
    end

    // ---- reference divider
    ref_div_if rdi ();
    logic ref_pend_r;
    logic [1:0] pwr;
    logic       ref_tick_r;
    assign rdi.ratio    = reference_config_word_r[pll_pkg::R_LSB - 2 +: pll_pkg::R_W];
    assign rdi.load_req = ref_pend_r;
    assign rdi.ref_tick = ref_tick_r;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ref_pend_r <= 1'b0;
            ref_tick_r <= 1'b0;
        end else begin
            ref_tick_r <= s2_r[4] & ~s3_r[4];
            if (rdi.load_done) begin
                ref_pend_r <= 1'b0;
            end
            if (en_fall && dest == pll_pkg::DEST_REFERENCE) begin
                ref_pend_r <= 1'b1;
            end
        end
    end

    ref_divider u_ref_div (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .rd      (rdi.div)
    );

    // ---- phase/frequency detector
    logic ff_ref_r;
    logic ff_div_r;
    logic set_ref;
    logic set_div;
    assign set_ref = sense_r ? m_out_r : rdi.ref_out;
    assign set_div = sense_r ? rdi.ref_out : m_out_r;

    // both set clears both at once, so no dead zone builds up
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ff_ref_r <= 1'b0;
            ff_div_r <= 1'b0;
        end else if ((ff_ref_r || set_ref) && (ff_div_r || set_div)) begin
            ff_ref_r <= 1'b0;
            ff_div_r <= 1'b0;
        end else begin
            ff_ref_r <= ff_ref_r | set_ref;
            ff_div_r <= ff_div_r | set_div;
        end
    end

    // ---- outputs
    logic pump_en;
    logic [3:0] gain_x2;
    assign pwr = {reference_config_word_r[pll_pkg::PWR_HI - 2], reference_config_word_r[pll_pkg::PWR_LO - 2]};

    always_comb begin
        case (pwr)
            pll_pkg::PWR_MON_OFF:   pump_en = 1'b1;
            pll_pkg::PWR_ALL_ON:    pump_en = 1'b1;
            pll_pkg::PWR_PUMP_OFF:  pump_en = 1'b0;
            pll_pkg::PWR_LOCK_GATE: pump_en = ~lock_level;
            default:                pump_en = 1'b1;
        endcase
        // gain code {high, low}
        case (gain_r)
            2'h0:    gain_x2 = 4'h2;
            2'h2:    gain_x2 = 4'h3;
            2'h1:    gain_x2 = 4'h5;
            2'h3:    gain_x2 = 4'h8;
            default: gain_x2 = 4'h2;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            modulus_high_o        <= 1'b0;
            prescaler_8_9_o       <= 1'b0;
            gain_mult_x2_o        <= 4'h2;
            pump_source_o         <= 1'b0;
            pump_sink_o           <= 1'b0;
            divided_ref_monitor_o <= 1'b0;
            divided_rf_monitor_o  <= 1'b0;
            monitors_on_o         <= 1'b0;
        end else begin
            modulus_high_o        <= mod_hi_r;
            prescaler_8_9_o       <= reference_config_word_r[pll_pkg::MOD_BIT - 2];
            gain_mult_x2_o        <= gain_x2;
            pump_source_o         <= ff_ref_r & pump_en;
            pump_sink_o           <= ff_div_r & pump_en;
            monitors_on_o         <= (pwr != pll_pkg::PWR_MON_OFF);
            divided_ref_monitor_o <= (pwr != pll_pkg::PWR_MON_OFF) && (sense_r ? m_out_r : rdi.ref_out);
            divided_rf_monitor_o  <= (pwr != pll_pkg::PWR_MON_OFF) && (sense_r ? rdi.ref_out : m_out_r);
        end
    end

    // ---- checks
    chk_shift_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        !en_level |=> $stable(sr_r)) else $error("shift while enable low");
    chk_shift_in: assert property (@(posedge clock_i) disable iff (reset_i)
        (sclk_rise && en_level) |=> sr_r[0] == $past(data_s2_r)) else $error("bit not shifted");
    chk_word_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        !en_fall |=> $stable(primary_divider_word_r) && $stable(alternate_divider_word_r)) else $error("buffer moved");
    chk_primary_load: assert property (@(posedge clock_i) disable iff (reset_i)
        (en_fall && dest == pll_pkg::DEST_PRIMARY) |=> primary_divider_word_r == $past(sr_r[23:2])
        && $stable(alternate_divider_word_r)) else $error("primary load wrong");
    chk_m_gate: assert property (@(posedge clock_i) disable iff (reset_i)
        (div_pend_r && !div_gate && !m_end) |=> $stable(shadow_r)) else $error("copy at low M count");
    chk_work_stable: assert property (@(posedge clock_i) disable iff (reset_i)
        !m_end |=> $stable(m_work_r) && $stable(a_work_r)) else $error("divider moved mid cycle");
    chk_pfd_clear: assert property (@(posedge clock_i) disable iff (reset_i)
        (ff_ref_r && ff_div_r) == 1'b0) else $error("both detector flops set");
    chk_pump_off: assert property (@(posedge clock_i) disable iff (reset_i)
        (pwr == pll_pkg::PWR_PUMP_OFF) [*2] |-> !pump_source_o && !pump_sink_o) else $error("pump on when off");
    chk_mod_start: assert property (@(posedge clock_i) disable iff (reset_i)
        m_end |=> mod_hi_r == (a_work_r != 4'h0)) else $error("cycle not at N+1");
    chk_a_only: assert property (@(posedge clock_i) disable iff (reset_i)
        (en_fall && dest == pll_pkg::DEST_A_ONLY && sel_level) |=>
        primary_divider_word_r[21:4] == $past(primary_divider_word_r[21:4])) else $error("A-only touched M");

    cov_primary: cover property (@(posedge clock_i) disable iff (reset_i)
        en_fall && dest == pll_pkg::DEST_PRIMARY);
    cov_ref_load: cover property (@(posedge clock_i) disable iff (reset_i) rdi.load_done);
    cov_toggle_copy: cover property (@(posedge clock_i) disable iff (reset_i)
        sel_toggle ##[1:200] (div_pend_r && div_gate));
    cov_pump: cover property (@(posedge clock_i) disable iff (reset_i) pump_source_o);
endmodule
`default_nettype wire

// file: src/ref_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ref_div_if;
    logic [12:0] ratio;
    logic        load_req;
    logic        load_done;
    logic        ref_tick;
    logic        ref_out;
    modport ctl (output ratio, output load_req, output ref_tick, input load_done, input ref_out);
    modport div (input ratio, input load_req, input ref_tick, output load_done, output ref_out);
endinterface
`default_nettype wire

// file: src/ref_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ref_divider (
    input  wire logic clock_i,    // system clock
    input  wire logic reset_i,    // async reset, high
    ref_div_if.div    rd          // divider side
);
    logic [pll_pkg::R_W-1:0] cnt_r;
    logic [pll_pkg::R_W-1:0] ratio_r;
    logic                    done_r;
    logic                    out_r;

    // shadow taken while the remaining count exceeds the gate or the running ratio is at or below it
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ratio_r <= pll_pkg::REFW_RST[pll_pkg::R_W-1:0];
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            // a ratio of 1 wraps on every tick, so there is no count to cut short
            if (rd.load_req && !done_r && (cnt_r > pll_pkg::R_GATE || ratio_r <= pll_pkg::R_GATE)) begin
                ratio_r <= rd.ratio;
                done_r  <= 1'b1;
            end
        end
    end

    // ratio 0 behaves as 1, so 1..8191 are all reachable
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= pll_pkg::R_GATE;
            out_r <= 1'b0;
        end else begin
            out_r <= 1'b0;
            if (rd.ref_tick) begin
                if (cnt_r <= pll_pkg::R_GATE) begin
                    cnt_r <= ratio_r;
                    out_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 13'h0001;
                end
            end
        end
    end

    assign rd.load_done = done_r;
    assign rd.ref_out   = out_r;

    chk_ref_gate: assert property (@(posedge clock_i) disable iff (reset_i)
        rd.load_done |-> ($past(cnt_r) > pll_pkg::R_GATE || $past(ratio_r) <= pll_pkg::R_GATE))
        else $error("ref load at low count");
    chk_ref_wrap: assert property (@(posedge clock_i) disable iff (reset_i)
        (rd.ref_tick && cnt_r <= pll_pkg::R_GATE) |=> rd.ref_out) else $error("ref output missed");
endmodule
`default_nettype wire
